/* slh_short_load.sv */
// Decode and execute of the short unsigned halfword load
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module slh_short_load (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Instruction issue
  input  wire logic        insnValid,
  input  wire logic [15:0] insnWord,
  input  wire logic [31:0] insnPc,
  output logic             insnReady,
  // Register file read port
  output logic [4:0]       gprRdIdx,
  input  wire logic [31:0] gprRdData,
  // Register file write port and flags
  output logic             wbEn,
  output logic [4:0]       wbIdx,
  output logic [31:0]      wbData,
  output logic             flagWe,
  // Memory bus
  output logic             memReq,
  output logic [31:0]      memAddr,
  output logic [1:0]       memResource,
  output logic             cycleSwitch,
  input  wire logic        memAck,
  input  wire logic [15:0] memRdata,
  // Interrupt
  input  wire logic        irq,
  output logic             abortValid,
  output logic [31:0]      retAddr,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic [1:0]       hresp
);

  slh_pkg::slh_state_t state;
  slh_pkg::slh_state_t next_state;

  logic        ctrlEnable;
  logic        isMatch;
  logic        take;
  logic [4:0]  destReg;
  logic [4:0]  dispReg;
  logic [31:0] pcReg;
  logic [31:0] effAddr;
  logic [1:0]  next_resource;
  logic [1:0]  lastRes;
  logic        abortNow;
  logic        finish;
  logic [31:0] loadCount;
  logic [31:0] abortCount;

  // ==========================================================
  // Decode
  // opcode match
  assign isMatch = insnWord[slh_pkg::OPC_HI:slh_pkg::OPC_LO] ==
                   slh_pkg::OPC_SHORT_HU;
  assign take    = insnValid && insnReady;

  assign effAddr = gprRdData + {27'h000_0000, dispReg};

  always_comb begin
    if (effAddr < slh_pkg::ROM_LIMIT) begin
      next_resource = slh_pkg::RES_ROM;
    end else if (effAddr >= slh_pkg::PERI_BASE &&
                 effAddr <  slh_pkg::PERI_LIMIT) begin
      next_resource = slh_pkg::RES_PERI;
    end else if (effAddr >= slh_pkg::RAM_BASE &&
                 effAddr <  slh_pkg::PERI_BASE) begin
      next_resource = slh_pkg::RES_RAM;
    end else begin
      next_resource = slh_pkg::RES_EXT;
    end
  end

  // or once the read has completed
  assign abortNow = irq && ((state == slh_pkg::ST_ADDR) ||
                            (state == slh_pkg::ST_BUS && memAck));
  assign finish   = state == slh_pkg::ST_BUS && memAck && !irq;

  // ==========================================================
  // Sequencer
  always_comb begin
    case (state)
      slh_pkg::ST_IDLE:
        next_state = (take && isMatch) ? slh_pkg::ST_ADDR
                                       : slh_pkg::ST_IDLE;
      slh_pkg::ST_ADDR:
        next_state = irq ? slh_pkg::ST_IDLE : slh_pkg::ST_BUS;
      slh_pkg::ST_BUS:
        next_state = memAck ? slh_pkg::ST_IDLE : slh_pkg::ST_BUS;
      default:
        next_state = slh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= slh_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      insnReady <= 1'b0;
    end else begin
      insnReady <= ctrlEnable && next_state == slh_pkg::ST_IDLE;
    end
  end

  // capture fields, offset low bit zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      destReg <= slh_pkg::ZERO_REG;
      dispReg <= 5'h00;
      pcReg   <= 32'h0000_0000;
    end else if (take && isMatch) begin
      destReg <= insnWord[slh_pkg::DEST_HI:slh_pkg::DEST_LO];
      dispReg <= {insnWord[slh_pkg::DISP_HI:slh_pkg::DISP_LO], 1'b0};
      pcReg   <= insnPc;
    end
  end

  // element pointer on the read port
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gprRdIdx <= slh_pkg::PTR_INDEX;
    end else begin
      gprRdIdx <= slh_pkg::PTR_INDEX;
    end
  end

  // ==========================================================
  // Memory bus
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      memReq      <= 1'b0;
      memAddr     <= 32'h0000_0000;
      memResource <= slh_pkg::RES_ROM;
      cycleSwitch <= 1'b0;
      lastRes     <= slh_pkg::RES_ROM;
    end else if (state == slh_pkg::ST_ADDR && !irq) begin
      memReq      <= 1'b1;
      memAddr     <= effAddr;
      memResource <= next_resource;
      // switch only on a new resource
      cycleSwitch <= next_resource != lastRes;
      lastRes     <= next_resource;
    end else if (memAck) begin
      memReq      <= 1'b0;
      cycleSwitch <= 1'b0;
    end
  end

  // ==========================================================
  // Write-back
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wbEn   <= 1'b0;
      wbIdx  <= slh_pkg::ZERO_REG;
      wbData <= 32'h0000_0000;
      flagWe <= 1'b0;
    end else begin
      wbEn   <= finish;
      wbIdx  <= destReg;
      wbData <= {16'h0000, memRdata};
      flagWe <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt abort
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      abortValid <= 1'b0;
      retAddr    <= 32'h0000_0000;
    end else begin
      abortValid <= abortNow;
      if (abortNow) begin
        retAddr <= pcReg;
      end
    end
  end

  // ==========================================================
  // Statistics for software
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      loadCount  <= 32'h0000_0000;
      abortCount <= 32'h0000_0000;
    end else begin
      if (finish) begin
        loadCount <= loadCount + 32'h0000_0001;
      end
      if (abortNow) begin
        abortCount <= abortCount + 32'h0000_0001;
      end
    end
  end

  slh_ahb_regs u_regs (
    .mclk       (mclk),
    .nrst       (nrst),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hreadyout  (hreadyout),
    .hrdata     (hrdata),
    .hresp      (hresp),
    .busy       (state != slh_pkg::ST_IDLE),
    .lastRes    (lastRes),
    .loadCount  (loadCount),
    .abortCount (abortCount),
    .lastAddr   (memAddr),
    .ctrlEnable (ctrlEnable)
  );

  // ==========================================================
  // Checks
  a_addr_form: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(memReq) |->
      memAddr == $past(gprRdData) + {27'h000_0000, $past(dispReg)})
    else $error("load address not element pointer plus offset");

  a_zero_extend: assert property (
    @(posedge mclk) disable iff (!nrst)
    (memReq && memAck && !irq) |=>
      wbEn && wbData == {16'h0000, $past(memRdata)})
    else $error("halfword not zero-extended into register");

  a_flags_kept: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state != slh_pkg::ST_IDLE) [*2] |-> !flagWe)
    else $error("flags written by load");

  a_decode_take: assert property (
    @(posedge mclk) disable iff (!nrst)
    (take && isMatch) |=> state == slh_pkg::ST_ADDR &&
      dispReg == {$past(insnWord[slh_pkg::DISP_HI:slh_pkg::DISP_LO]),
                  1'b0} &&
      destReg ==
        $past(insnWord[slh_pkg::DEST_HI:slh_pkg::DEST_LO]))
    else $error("short load decode wrong");

  a_abort_nowb: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state == slh_pkg::ST_ADDR && irq) |=>
      abortValid && !wbEn ##1 !memReq)
    else $error("interrupt did not abort load");

  a_ret_addr: assert property (
    @(posedge mclk) disable iff (!nrst)
    abortValid |-> retAddr == pcReg)
    else $error("return address not load address");

  a_switch_same: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(memReq) |->
      cycleSwitch == (memResource != $past(lastRes)))
    else $error("bus cycle switch on same resource");

  a_read_abort: assert property (
    @(posedge mclk) disable iff (!nrst)
    (memReq && memAck && irq) |=>
      abortValid && !wbEn && state == slh_pkg::ST_IDLE)
    else $error("completed read not abandoned on interrupt");

  a_ptr_port: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(memReq) |-> $past(gprRdIdx) == slh_pkg::PTR_INDEX &&
      $past(state) == slh_pkg::ST_ADDR)
    else $error("address not formed from element pointer port");

endmodule : slh_short_load
`default_nettype wire

/* slh_pkg.sv */
// Constants, types and register map of the short unsigned halfword load
// Functional notes
// - Address is element_pointer plus zero-extended short_offset.
// - Zero-extended halfword to dest_register; flags untouched.
// - Match rrrrr0000111dddd; offset low bit zero.
// - Interrupt during load aborts it, interrupt served.
// - Return address is the load's own address.
// - Cycle type switches only when resource changes.
// - Read may complete before abort; reissued later.
package slh_pkg;

  // ==========================================================
  // Instruction layout
  localparam int         DEST_HI     = 15;
  localparam int         DEST_LO     = 11;
  localparam int         OPC_HI      = 10;
  localparam int         OPC_LO      = 4;
  localparam int         DISP_HI     = 3;
  localparam int         DISP_LO     = 0;
  localparam logic [6:0] OPC_SHORT_HU = 7'h07;
  localparam logic [4:0] PTR_INDEX   = 5'h1E;
  localparam logic [4:0] ZERO_REG    = 5'h00;

  // ==========================================================
  // Memory resources and their address windows
  localparam logic [1:0]  RES_ROM    = 2'h0;
  localparam logic [1:0]  RES_RAM    = 2'h1;
  localparam logic [1:0]  RES_PERI   = 2'h2;
  localparam logic [1:0]  RES_EXT    = 2'h3;
  localparam logic [31:0] ROM_LIMIT  = 32'h0010_0000;
  localparam logic [31:0] RAM_BASE   = 32'h03FF_0000;
  localparam logic [31:0] PERI_BASE  = 32'h03FF_F000;
  localparam logic [31:0] PERI_LIMIT = 32'h0400_0000;

  // ==========================================================
  // Register map (byte offsets) and reset values
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_LOADS  = 8'h08;
  localparam logic [7:0]  REG_ABORTS = 8'h0C;
  localparam logic [7:0]  REG_LADDR  = 8'h10;
  localparam logic        CTRL_RST   = 1'b1;
  localparam logic [1:0]  HRESP_OKAY = 2'h0;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ADDR = 3'h2,
    ST_BUS  = 3'h4
  } slh_state_t;

endpackage : slh_pkg

/* slh_ahb_regs.sv */
// AHB-Lite register slave of the short unsigned halfword load
`timescale 1ns/100ps
`default_nettype none
module slh_ahb_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic [1:0]       hresp,
  // Block state
  input  wire logic        busy,
  input  wire logic [1:0]  lastRes,
  input  wire logic [31:0] loadCount,
  input  wire logic [31:0] abortCount,
  input  wire logic [31:0] lastAddr,
  output logic             ctrlEnable
);

  logic       addrPhase;
  logic       wrPend;
  logic [7:0] wrAddr;
  logic       ctrlView;

  assign addrPhase = hsel && htrans[1] && hready;
  // Read in the cycle after a control write sees the new value
  assign ctrlView  = (wrPend && wrAddr == slh_pkg::REG_CTRL) ?
                     hwdata[0] : ctrlEnable;

  // ==========================================================
  // Handshake
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp     <= slh_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= slh_pkg::HRESP_OKAY;
    end
  end

  // ==========================================================
  // Write path
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= addrPhase && hwrite && hsize == 3'h2;
      wrAddr <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrlEnable <= slh_pkg::CTRL_RST;
    end else if (wrPend && wrAddr == slh_pkg::REG_CTRL) begin
      ctrlEnable <= hwdata[0];
    end
  end

  // ==========================================================
  // Read path, data ready in the data phase
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        slh_pkg::REG_CTRL:   hrdata <= {31'h0000_0000, ctrlView};
        slh_pkg::REG_STATUS: hrdata <= {29'h0000_0000, lastRes, busy};
        slh_pkg::REG_LOADS:  hrdata <= loadCount;
        slh_pkg::REG_ABORTS: hrdata <= abortCount;
        slh_pkg::REG_LADDR:  hrdata <= lastAddr;
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : slh_ahb_regs
`default_nettype wire

/* slh_mem_model.sv */
// Memory and peripheral resource model answering the load's reads
`timescale 1ns/100ps
`default_nettype none
module slh_mem_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Memory bus
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic [3:0]  delay,
  output logic             memAck,
  output logic [15:0]      memRdata
);
  logic [3:0] waitCnt;

  // ==========================================================
  // Acknowledge after the requested wait
  always_ff @(posedge mclk) begin
    if (!nrst || !memReq || memAck) begin
      memAck  <= 1'b0;
      waitCnt <= 4'h0;
    end else if (waitCnt >= delay) begin
      memAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end

  // read data depends on address only
  // Data only valid with the acknowledge, toggles otherwise
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      memRdata <= 16'h0000;
    end else if (memReq && !memAck && waitCnt >= delay) begin
      memRdata <= memAddr[15:0] ^ 16'h5A3C;
    end else begin
      memRdata <= ~memRdata;
    end
  end
endmodule : slh_mem_model
`default_nettype wire

/* slh_short_load_bench.sv */
// Self-checking bench of the short unsigned halfword load
`timescale 1ns/100ps
`default_nettype none
module slh_short_load_bench;
  // ==========================================================
  // Signals
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        insnValid = 1'b0;
  logic [15:0] insnWord = 16'h0000;
  logic [31:0] insnPc = 32'h0000_0000;
  logic        irq = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0]  delay = 4'h0;
  logic [31:0] elemPtr = 32'h0000_0000;
  logic        insnReady, wbEn, flagWe, memReq, cycleSwitch, memAck;
  logic        abortValid, hready, hreadyout, prevReq;
  logic [4:0]  gprRdIdx, wbIdx;
  logic [1:0]  memResource, hresp, prevRes;
  logic [15:0] memRdata;
  logic [31:0] gprRdData, wbData, memAddr, retAddr, hrdata, rd, lastAddr;
  logic [37:0] resQ[$];
  logic [34:0] adrQ[$];
  logic [31:0] base [4] = '{32'h0000_1000, slh_pkg::RAM_BASE + 32'h0000_0100,
                            slh_pkg::PERI_BASE + 32'h0000_0040, 32'h8000_0000};
  int          seed = 32'h09457202;
  int          nMismatch = 0;
  int          checkCount = 0;
  int          nLoads = 0;
  int          nAborts = 0;

  always #5 mclk = ~mclk;
  assign hready = hreadyout;
  assign gprRdData = (gprRdIdx === slh_pkg::PTR_INDEX) ? elemPtr : ~elemPtr;

  slh_short_load DUT (
    .mclk(mclk), .nrst(nrst), .insnValid(insnValid), .insnWord(insnWord),
    .insnPc(insnPc), .insnReady(insnReady), .gprRdIdx(gprRdIdx),
    .gprRdData(gprRdData), .wbEn(wbEn), .wbIdx(wbIdx), .wbData(wbData),
    .flagWe(flagWe), .memReq(memReq), .memAddr(memAddr),
    .memResource(memResource), .cycleSwitch(cycleSwitch), .memAck(memAck),
    .memRdata(memRdata), .irq(irq), .abortValid(abortValid),
    .retAddr(retAddr), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  slh_mem_model mem (
    .mclk(mclk), .nrst(nrst), .memReq(memReq), .memAddr(memAddr),
    .delay(delay), .memAck(memAck), .memRdata(memRdata));

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    check("hresp", {30'h0, hresp}, {30'h0, slh_pkg::HRESP_OKAY});
  endtask : ahb

  task automatic load(input logic [4:0] d, input logic [3:0] o,
                      input logic [6:0] opc, input logic [1:0] im,
                      input logic [1:0] rs);
    logic [31:0] a;
    logic [31:0] pc;
    pc = $random(seed);
    elemPtr <= base[rs];
    a = base[rs] + {27'h0, o, 1'b0};
    insnWord  <= {d, opc, o};
    insnPc    <= pc;
    insnValid <= 1'b1;
    do @(posedge mclk); while (insnReady !== 1'b1);
    insnValid <= 1'b0;
    if (opc != slh_pkg::OPC_SHORT_HU) begin
      repeat (4) begin
        @(posedge mclk);
        check("ignoredReq", {31'h0, memReq}, 32'h0);
      end
      return;
    end
    irq <= (im == 2'h1);
    if (im != 2'h1) begin
      adrQ.push_back({rs != prevRes, rs, a});
      prevRes  = rs;
      lastAddr = a;
    end
    resQ.push_back(im == 2'h0 ? {1'b0, d, 16'h0000, a[15:0] ^ 16'h5A3C}
                              : {1'b1, 5'h00, pc});
    do begin
      @(posedge mclk);
      irq <= (im == 2'h2) && (memReq === 1'b1 || irq === 1'b1) &&
             wbEn !== 1'b1 && abortValid !== 1'b1;
    end while (wbEn !== 1'b1 && abortValid !== 1'b1);
    if (im == 2'h0) nLoads++;
    else nAborts++;
  endtask : load

  task automatic close_out();
    $display("Checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // Result watcher
  always @(posedge mclk) begin : watch
    logic [37:0] e;
    logic [34:0] m;
    if (nrst === 1'b1 && (wbEn === 1'b1 || abortValid === 1'b1)) begin
      check("resQueue", {31'h0, (resQ.size() > 0)}, 32'h1);
      e = (resQ.size() > 0) ? resQ.pop_front() : 38'h0;
      check("abortValid", {31'h0, abortValid}, {31'h0, e[37]});
      if (e[37]) check("retAddr", retAddr, e[31:0]);
      else check("wbIdx", {27'h0, wbIdx}, {27'h0, e[36:32]});
      if (!e[37]) check("wbData", wbData, e[31:0]);
    end
    if (wbEn === 1'b1) check("flagWe", {31'h0, flagWe}, 32'h0);
    if (memReq === 1'b1 && prevReq !== 1'b1) begin
      check("adrQueue", {31'h0, (adrQ.size() > 0)}, 32'h1);
      m = (adrQ.size() > 0) ? adrQ.pop_front() : 35'h0;
      check("memAddr", memAddr, m[31:0]);
      check("memResource", {30'h0, memResource}, {30'h0, m[33:32]});
      check("cycleSwitch", {31'h0, cycleSwitch}, {31'h0, m[34]});
    end
    prevReq <= memReq;
  end

  // ==========================================================
  // Main sequence
  initial begin : main
    logic [4:0] d;
    prevRes = slh_pkg::RES_ROM;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    ahb(1'b0, slh_pkg::REG_LOADS, 32'h0, rd);
    check("LOADS", rd, 32'h0);
    ahb(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    ahb(1'b0, slh_pkg::REG_CTRL, 32'h0, rd);
    check("CTRL", rd, 32'h1);
    ahb(1'b1, slh_pkg::REG_CTRL, 32'h0, rd);
    ahb(1'b0, slh_pkg::REG_CTRL, 32'h0, rd);
    check("CTRL", rd, 32'h0);
    insnWord  <= {5'h01, slh_pkg::OPC_SHORT_HU, 4'h1};
    insnValid <= 1'b1;
    repeat (4) @(posedge mclk);
    check("heldOff", {31'h0, memReq | insnReady}, 32'h0);
    insnValid <= 1'b0;
    ahb(1'b1, slh_pkg::REG_CTRL, 32'h1, rd);
    ahb(1'b0, slh_pkg::REG_CTRL, 32'h0, rd);
    check("CTRL", rd, 32'h1);
    for (int i = 0; i < 16; i++) begin
      d = 5'($random(seed));
      if (d == slh_pkg::ZERO_REG) d = 5'h01;
      delay <= 4'($random(seed));
      load(d, i == 0 ? 4'h0 : (i == 1 ? 4'hF : 4'($random(seed))),
           slh_pkg::OPC_SHORT_HU,
           i < 3 ? 2'h0 : 2'($unsigned($random(seed)) % 3),
           2'($random(seed)));
      if (i == 5) load(5'h03, 4'h2, 7'h0F, 2'h0, 2'h0);
    end
    ahb(1'b0, slh_pkg::REG_LOADS, 32'h0, rd);
    check("LOADS", rd, nLoads);
    ahb(1'b0, slh_pkg::REG_ABORTS, 32'h0, rd);
    check("ABORTS", rd, nAborts);
    ahb(1'b0, slh_pkg::REG_LADDR, 32'h0, rd);
    check("LADDR", rd, lastAddr);
    ahb(1'b0, slh_pkg::REG_STATUS, 32'h0, rd);
    check("STATUS", rd, {29'h0, prevRes, 1'b0});
    close_out();
  end

  initial begin : watchdog
    #200000;
    nMismatch++;
    close_out();
  end
endmodule : slh_short_load_bench
`default_nettype wire
